// file: hdl/gcr_cfg.svh
// Offsets, field positions, reset values and timing counts of the global registers
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define GCR_ADDR_ID 5'h00
`define GCR_ADDR_CR1 5'h02
`define GCR_ADDR_CR2 5'h04
`define GCR_ADDR_GIOCR 5'h0A
`define GCR_ADDR_ISR 5'h10
`define GCR_ADDR_ISRIE 5'h12
`define GCR_ADDR_SR 5'h14
`define GCR_ADDR_SRL 5'h16
`define GCR_ADDR_SRIE 5'h18
`define GCR_ADDR_GIORR 5'h1C

// ----------------------------------------------------------------
// Control register fields, masks and reset value
// ----------------------------------------------------------------
`define GCR_CR1_IRQ_IDLE 14
`define GCR_CR1_ERR_INS 7
`define GCR_CR1_ERR_SEL 6
`define GCR_CR1_MON_HI 5
`define GCR_CR1_MON_LO 4
`define GCR_CR1_MON_REQ 3
`define GCR_CR1_CLR_RD 2
`define GCR_CR1_DP_RST 1
`define GCR_CR1_RST 0
`define GCR_CR1_MASK 16'h40FF
`define GCR_CR1_RESET 16'h0002
`define GCR_CR2_MASK 16'h0F0E
`define GCR_ZERO16 16'h0000

// ----------------------------------------------------------------
// Status fields and pins
// ----------------------------------------------------------------
`define GCR_SR_MON_DONE 0
`define GCR_PIN_SIX 5
`define GCR_PIN_EIGHT 7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GCR_CLK_NS 10
`define GCR_MIN_RST_NS 100
`define GCR_MIN_RST_CYC ((`GCR_MIN_RST_NS + `GCR_CLK_NS - 1) / `GCR_CLK_NS)

`endif

// file: hdl/gcr_pkg.sv
// Types shared by the global control register modules
`default_nettype none
package gcr_pkg;
  typedef logic [15:0] reg16_t;
  typedef enum logic [2:0] {
    SRC_REG = 3'b001,
    SRC_PIN = 3'b010,
    SRC_TICK = 3'b100
  } trig_src_e;
endpackage : gcr_pkg
`default_nettype wire

// file: hdl/trig_if.sv
// Signals between the register bank and one trigger selector
`timescale 1ns/1ps
`default_nettype none
interface trig_if;
  logic [1:0] sel;
  logic reg_bit;
  logic pin;
  logic tick;
  logic fire;
  modport ctl (output sel, output reg_bit, output pin, output tick, input fire);
  modport trg (input sel, input reg_bit, input pin, input tick, output fire);
endinterface : trig_if
`default_nettype wire

// file: hdl/gcr_edge_trigger.sv
// Trigger source selector with rising edge detection
`timescale 1ns/1ps
`default_nettype none
module gcr_edge_trigger (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Trigger sources and pulse
  trig_if.trg t
);
  function automatic gcr_pkg::trig_src_e decode_src(input logic [1:0] s);
    if (s[1]) begin
      return gcr_pkg::SRC_TICK;
    end else if (s[0]) begin
      return gcr_pkg::SRC_PIN;
    end
    return gcr_pkg::SRC_REG;
  endfunction : decode_src

  gcr_pkg::trig_src_e src;
  logic src_lvl;
  logic prev_r;
  logic fire_r;

  assign src = decode_src(t.sel);
  // Unselected sources never reach the edge detector
  assign src_lvl = (src == gcr_pkg::SRC_TICK) ? t.tick :
                   (src == gcr_pkg::SRC_PIN) ? t.pin : t.reg_bit;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_r <= 1'b0;
      fire_r <= 1'b0;
    end else begin
      prev_r <= src_lvl;
      fire_r <= src_lvl & ~prev_r;
    end
  end
  assign t.fire = fire_r;

  property p_fire_edge;
    @(posedge i_clk) disable iff (!i_rst_n)
    t.fire |-> $past(src_lvl) && !$past(src_lvl, 2);
  endproperty
  a_fire_edge: assert property (p_fire_edge) else $error("trigger fired without edge");
endmodule : gcr_edge_trigger
`default_nettype wire

// file: hdl/global_control_registers.sv
// Global identification and control register bank
//
// Contract
// - Idle interrupt pin: float or drive high
// - Pending interrupt always drives pin low
// - Insert bit rising edge inserts one error
// - Insert bit ignored when pin source chosen
// - Insert source: register bit or pin six
// - Update trigger: bit, pin eight, second tick
// - ID upper nibble equals test-port revision
// - ID low twelve bits equal part code
// - Update request edge loads counters; fall clears done
// - Latched status cleared on write or read
// - Datapath reset set after reset, held 100ns
// - Soft reset defaults everything except itself
`timescale 1ns/1ps
`default_nettype none
`include "gcr_cfg.svh"
module global_control_registers #(
  parameter logic [3:0] REV_ID = 4'h1,     // Arbitrary value
  parameter logic [11:0] PART_CODE = 12'h5A3  // Arbitrary value
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // Register port
  input wire logic I_CS,
  input wire logic I_WE,
  input wire logic I_RE,
  input wire logic [4:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  output logic [15:0] O_RDATA,
  // Device pins
  input wire logic [7:0] I_GPIO,
  output logic O_INT_B,
  output logic O_INT_OE,
  // Device internal
  input wire logic [15:0] I_PORT_IRQ,
  input wire logic I_ONE_SEC_TICK,
  input wire logic I_PM_LOADED,
  output logic O_ERR_INSERT,
  output logic O_PM_UPDATE,
  output logic O_DATAPATH_RST,
  output logic [15:0] O_CR2,
  output logic [15:0] O_GPIO_CTRL,
  output logic [31:0] O_TAP_IDCODE
);
  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;
  logic [7:0] gpio_meta_r;
  logic [7:0] gpio_s_r;
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      gpio_meta_r <= 8'h00;
      gpio_s_r <= 8'h00;
    end else begin
      gpio_meta_r <= I_GPIO;
      gpio_s_r <= gpio_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction : hit
  wire wr = I_CS & I_WE;
  wire rd = I_CS & I_RE;
  wire wr_cr1 = wr & hit(I_ADDR, `GCR_ADDR_CR1);
  wire wr_cr2 = wr & hit(I_ADDR, `GCR_ADDR_CR2);
  wire wr_giocr = wr & hit(I_ADDR, `GCR_ADDR_GIOCR);
  wire wr_isrie = wr & hit(I_ADDR, `GCR_ADDR_ISRIE);
  wire wr_srl = wr & hit(I_ADDR, `GCR_ADDR_SRL);
  wire wr_srie = wr & hit(I_ADDR, `GCR_ADDR_SRIE);
  wire rd_srl = rd & hit(I_ADDR, `GCR_ADDR_SRL);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  gcr_pkg::reg16_t cr1_r, cr1_wv, cr1_nxt;
  gcr_pkg::reg16_t cr2_r, giocr_r, isrie_r, srie_r;
  wire soft_rst = cr1_r[`GCR_CR1_RST];
  // Soft reset keeps only its own bit, which software lowers itself
  assign cr1_wv = wr_cr1 ? (I_WDATA & `GCR_CR1_MASK) : cr1_r;
  assign cr1_nxt = cr1_wv[`GCR_CR1_RST] ? (`GCR_CR1_RESET | 16'h0001) : cr1_wv;
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cr1_r <= `GCR_CR1_RESET;
    end else begin
      cr1_r <= cr1_nxt;
    end
  end
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cr2_r <= `GCR_ZERO16;
      giocr_r <= `GCR_ZERO16;
      isrie_r <= `GCR_ZERO16;
      srie_r <= `GCR_ZERO16;
    end else if (soft_rst) begin
      cr2_r <= `GCR_ZERO16;
      giocr_r <= `GCR_ZERO16;
      isrie_r <= `GCR_ZERO16;
      srie_r <= `GCR_ZERO16;
    end else begin
      cr2_r <= wr_cr2 ? (I_WDATA & `GCR_CR2_MASK) : cr2_r;
      giocr_r <= wr_giocr ? I_WDATA : giocr_r;
      isrie_r <= wr_isrie ? I_WDATA : isrie_r;
      srie_r <= wr_srie ? {15'h0000, I_WDATA[`GCR_SR_MON_DONE]} : srie_r;
    end
  end

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  trig_if err_if ();
  trig_if mon_if ();

  assign err_if.sel = {1'b0, cr1_r[`GCR_CR1_ERR_SEL]};
  assign err_if.reg_bit = cr1_r[`GCR_CR1_ERR_INS];
  assign err_if.pin = gpio_s_r[`GCR_PIN_SIX];
  assign err_if.tick = 1'b0;
  assign mon_if.sel = cr1_r[`GCR_CR1_MON_HI:`GCR_CR1_MON_LO];
  assign mon_if.reg_bit = cr1_r[`GCR_CR1_MON_REQ];
  assign mon_if.pin = gpio_s_r[`GCR_PIN_EIGHT];
  assign mon_if.tick = I_ONE_SEC_TICK;
  gcr_edge_trigger u_err_trig (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .t(err_if)
  );
  gcr_edge_trigger u_mon_trig (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .t(mon_if)
  );
  assign O_ERR_INSERT = err_if.fire;
  assign O_PM_UPDATE = mon_if.fire;

  // ----------------------------------------------------------------
  // Update-done status and its latched copy
  // ----------------------------------------------------------------
  logic pmu_prev_r, pms_r, srl_r;
  // Lowering the request bit clears done; a load in that cycle wins
  wire pms_clr = pmu_prev_r & ~cr1_r[`GCR_CR1_MON_REQ];
  wire pms_nxt = I_PM_LOADED | (pms_r & ~pms_clr);
  wire srl_clr = cr1_r[`GCR_CR1_CLR_RD] ? rd_srl : (wr_srl & I_WDATA[`GCR_SR_MON_DONE]);
  wire srl_nxt = I_PM_LOADED | (srl_r & ~srl_clr);
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pmu_prev_r <= 1'b0;
      pms_r <= 1'b0;
      srl_r <= 1'b0;
    end else if (soft_rst) begin
      pmu_prev_r <= 1'b0;
      pms_r <= 1'b0;
      srl_r <= 1'b0;
    end else begin
      pmu_prev_r <= cr1_r[`GCR_CR1_MON_REQ];
      pms_r <= pms_nxt;
      srl_r <= srl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [15:0] id_word = {REV_ID, PART_CODE};
  wire [15:0] status_word = {15'h0000, pms_r};
  wire [15:0] latched_word = {15'h0000, srl_r};
  wire [15:0] pin_word = {8'h00, gpio_s_r};
  wire [15:0] rd_mux =
    hit(I_ADDR, `GCR_ADDR_ID) ? id_word :
    hit(I_ADDR, `GCR_ADDR_CR1) ? cr1_r :
    hit(I_ADDR, `GCR_ADDR_CR2) ? cr2_r :
    hit(I_ADDR, `GCR_ADDR_GIOCR) ? giocr_r :
    hit(I_ADDR, `GCR_ADDR_ISR) ? I_PORT_IRQ :
    hit(I_ADDR, `GCR_ADDR_ISRIE) ? isrie_r :
    hit(I_ADDR, `GCR_ADDR_SR) ? status_word :
    hit(I_ADDR, `GCR_ADDR_SRL) ? latched_word :
    hit(I_ADDR, `GCR_ADDR_SRIE) ? srie_r :
    hit(I_ADDR, `GCR_ADDR_GIORR) ? pin_word : `GCR_ZERO16;
  logic [15:0] rdata_r;
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `GCR_ZERO16;
    end else if (rd) begin
      rdata_r <= rd_mux;
    end
  end
  assign O_RDATA = rdata_r;

  // ----------------------------------------------------------------
  // Interrupt pin and datapath reset
  // ----------------------------------------------------------------
  wire pending = (|(I_PORT_IRQ & isrie_r)) | (srl_r & srie_r[`GCR_SR_MON_DONE]);
  wire dp_req = cr1_r[`GCR_CR1_DP_RST] | soft_rst;
  logic int_r, int_oe_r, dp_rst_r;
  logic [3:0] dp_cnt_r;
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      int_r <= 1'b1;
      int_oe_r <= 1'b0;
      dp_cnt_r <= 4'h0;
      dp_rst_r <= 1'b1;
    end else begin
      int_r <= ~pending;
      int_oe_r <= pending | cr1_r[`GCR_CR1_IRQ_IDLE];
      // Stretch keeps the datapath in reset even for a too short pulse
      dp_cnt_r <= dp_req ? 4'(`GCR_MIN_RST_CYC - 1) :
                  (dp_cnt_r != 4'h0) ? dp_cnt_r - 4'h1 : dp_cnt_r;
      dp_rst_r <= dp_req | (dp_cnt_r != 4'h0);
    end
  end
  assign O_INT_B = int_r;
  assign O_INT_OE = int_oe_r;
  assign O_DATAPATH_RST = dp_rst_r;
  assign O_CR2 = cr2_r;
  assign O_GPIO_CTRL = giocr_r;
  assign O_TAP_IDCODE = {REV_ID, 4'h0, PART_CODE, 11'h000, 1'b1};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!rst_n);
  property p_int_low;
    $past(pending) |-> !O_INT_B && O_INT_OE;
  endproperty
  a_int_low: assert property (p_int_low) else $error("pending interrupt not low");
  property p_int_idle;
    !$past(pending) |-> O_INT_B && (O_INT_OE == $past(cr1_r[`GCR_CR1_IRQ_IDLE]));
  endproperty
  a_int_idle: assert property (p_int_idle) else $error("idle pin drive wrong");
  property p_err_ins;
    $rose(cr1_r[`GCR_CR1_ERR_INS]) && !cr1_r[`GCR_CR1_ERR_SEL] &&
    !$past(cr1_r[`GCR_CR1_ERR_SEL]) |=> O_ERR_INSERT;
  endproperty
  a_err_ins: assert property (p_err_ins) else $error("error not inserted");
  property p_err_blk;
    cr1_r[`GCR_CR1_ERR_SEL] && $past(cr1_r[`GCR_CR1_ERR_SEL]) &&
    !$rose(gpio_s_r[`GCR_PIN_SIX]) |=> !O_ERR_INSERT;
  endproperty
  a_err_blk: assert property (p_err_blk) else $error("insert bit not ignored");
  property p_mon_tick;
    mon_if.sel[1] && $past(mon_if.sel[1]) && $rose(I_ONE_SEC_TICK) |=> O_PM_UPDATE;
  endproperty
  a_mon_tick: assert property (p_mon_tick) else $error("second tick missed");
  property p_id;
    $past(rd && hit(I_ADDR, `GCR_ADDR_ID)) |->
    O_RDATA[15:12] == O_TAP_IDCODE[31:28] && O_RDATA[11:0] == O_TAP_IDCODE[23:12];
  endproperty
  a_id: assert property (p_id) else $error("id mismatch");
  property p_rw;
    $past(wr_isrie) && !$past(soft_rst) |-> isrie_r == $past(I_WDATA);
  endproperty
  a_rw: assert property (p_rw) else $error("enable not written");
  property p_unused;
    $past(rd && I_ADDR[0]) |-> O_RDATA == `GCR_ZERO16;
  endproperty
  a_unused: assert property (p_unused) else $error("unused address not zero");
  property p_pms_clr;
    $fell(cr1_r[`GCR_CR1_MON_REQ]) && !I_PM_LOADED |=> !pms_r;
  endproperty
  a_pms_clr: assert property (p_pms_clr) else $error("done not cleared");
  property p_clr_rd;
    rd_srl && cr1_r[`GCR_CR1_CLR_RD] && !I_PM_LOADED && !soft_rst |=> !srl_r;
  endproperty
  a_clr_rd: assert property (p_clr_rd) else $error("latched not cleared on read");
  property p_dp_hold;
    $fell(dp_req) |-> O_DATAPATH_RST [*8];
  endproperty
  a_dp_hold: assert property (p_dp_hold) else $error("datapath reset too short");
  property p_soft;
    $past(soft_rst) |-> isrie_r == `GCR_ZERO16 && cr1_r[`GCR_CR1_DP_RST];
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left state");
  property p_rst_val;
    $rose(rst_n) |-> cr1_r == `GCR_CR1_RESET;
  endproperty
  a_rst_val: assert property (@(posedge I_CLK) p_rst_val) else $error("bad reset value");
endmodule : global_control_registers
`default_nettype wire

// file: test/global_control_registers_tb.sv
// Self-checking testbench of the global control register bank
`timescale 1ns/1ps
`default_nettype none
`include "gcr_cfg.svh"
module global_control_registers_tb;
  localparam logic [3:0] REV = 4'h6;      // Arbitrary value
  localparam logic [11:0] PART = 12'h3C9; // Arbitrary value
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs = 1'b0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic [7:0] gpio = 8'h00;
  logic [15:0] port_irq = 16'h0000;
  logic tick = 1'b0;
  logic pm_loaded = 1'b0;
  wire [15:0] rdata;
  wire int_b;
  wire int_oe;
  wire err_ins;
  wire pm_upd;
  wire dp_rst;
  wire [31:0] tap_id;
  wire [15:0] cr2_out;
  wire [15:0] gio_ctrl;
  int err_total = 0;
  int num_checks = 0;
  int n_err = 0;
  int n_pm = 0;
  int cycles = 0;

  global_control_registers #(.REV_ID(REV), .PART_CODE(PART)) DUT (
    .I_CLK(clk), .I_RST_B(rst_b), .I_CS(cs), .I_WE(we), .I_RE(re), .I_ADDR(addr),
    .I_WDATA(wdata), .O_RDATA(rdata), .I_GPIO(gpio), .O_INT_B(int_b), .O_INT_OE(int_oe),
    .I_PORT_IRQ(port_irq), .I_ONE_SEC_TICK(tick), .I_PM_LOADED(pm_loaded),
    .O_ERR_INSERT(err_ins), .O_PM_UPDATE(pm_upd), .O_DATAPATH_RST(dp_rst),
    .O_CR2(cr2_out), .O_GPIO_CTRL(gio_ctrl), .O_TAP_IDCODE(tap_id)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------------------------------
  // Counted mid-cycle, away from the edge that launches each pulse
  always @(negedge clk) begin
    if (err_ins === 1'b1) n_err++;
    if (pm_upd === 1'b1) n_pm++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    cyc(1);
    cs = 1'b1;
    we = 1'b1;
    addr = a;
    wdata = d;
    cyc(1);
    cs = 1'b0;
    we = 1'b0;
  endtask : wr

  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp, input string what);
    cyc(1);
    cs = 1'b1;
    re = 1'b1;
    addr = a;
    cyc(1);
    cs = 1'b0;
    re = 1'b0;
    chk(rdata, exp, what);
  endtask : rdchk

  // Pulses are counted over a window long enough for the pin synchronisers
  task automatic pulses(input int e, input int p, input string what);
    cyc(8);
    chk(16'(n_err), 16'(e), {what, " insert pulses"});
    chk(16'(n_pm), 16'(p), {what, " update pulses"});
    n_err = 0;
    n_pm = 0;
  endtask : pulses

  task automatic pm_done_pulse();
    cyc(1);
    pm_loaded = 1'b1;
    cyc(1);
    pm_loaded = 1'b0;
  endtask : pm_done_pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(16'(dp_rst), 16'h0001, "datapath reset after reset");
    rdchk(`GCR_ADDR_CR1, 16'h0002, "control one reset");
    rdchk(`GCR_ADDR_ID, {REV, PART}, "id word");
    chk({tap_id[31:28], tap_id[23:12]}, {REV, PART}, "test-port code");
    chk(16'({int_b, int_oe}), 16'h0002, "idle pin floats");
  endtask : t_reset

  task automatic t_access();
    wr(`GCR_ADDR_ID, 16'hFFFF);
    rdchk(`GCR_ADDR_ID, {REV, PART}, "id write ignored");
    wr(5'h06, 16'hFFFF);
    rdchk(5'h06, 16'h0000, "unused address");
    wr(5'h03, 16'hFFFF);
    rdchk(5'h03, 16'h0000, "odd address");
    wr(`GCR_ADDR_ISRIE, 16'hA5C3);
    rdchk(`GCR_ADDR_ISRIE, 16'hA5C3, "enable readback");
    wr(`GCR_ADDR_SR, 16'hFFFF);
    rdchk(`GCR_ADDR_SR, 16'h0000, "status write ignored");
    wr(`GCR_ADDR_CR1, 16'hFFFC);
    rdchk(`GCR_ADDR_CR1, 16'h40FC, "control one unused bits");
    wr(`GCR_ADDR_CR2, 16'hFFFF);
    rdchk(`GCR_ADDR_CR2, 16'h0F0E, "control two unused bits");
    chk(cr2_out, 16'h0F0E, "control two out");
    wr(`GCR_ADDR_GIOCR, 16'h5AA5);
    rdchk(`GCR_ADDR_GIOCR, 16'h5AA5, "pin control readback");
    chk(gio_ctrl, 16'h5AA5, "pin control out");
    wr(`GCR_ADDR_CR1, 16'h0000);
    wr(`GCR_ADDR_ISRIE, 16'h0000);
  endtask : t_access

  task automatic t_irq();
    port_irq = 16'h0100;
    cyc(3);
    chk(16'({int_b, int_oe}), 16'h0002, "masked source");
    rdchk(`GCR_ADDR_ISR, 16'h0100, "interrupt status");
    wr(`GCR_ADDR_CR1, 16'h4000);
    cyc(3);
    chk(16'({int_b, int_oe}), 16'h0003, "idle pin driven high");
    wr(`GCR_ADDR_ISRIE, 16'h0100);
    cyc(3);
    chk(16'({int_b, int_oe}), 16'h0001, "pending drive mode one");
    wr(`GCR_ADDR_CR1, 16'h0000);
    cyc(3);
    chk(16'({int_b, int_oe}), 16'h0001, "pending drive mode zero");
    port_irq = 16'h0000;
    cyc(3);
    chk(16'({int_b, int_oe}), 16'h0002, "pending gone");
    wr(`GCR_ADDR_ISRIE, 16'h0000);
  endtask : t_irq

  task automatic t_err();
    n_err = 0;
    n_pm = 0;
    gpio[5] = 1'b1;
    pulses(0, 0, "pin six with bit source");
    rdchk(`GCR_ADDR_GIORR, 16'h0020, "pin readback");
    gpio[5] = 1'b0;
    wr(`GCR_ADDR_CR1, 16'h0080);
    pulses(1, 0, "insert bit rise");
    wr(`GCR_ADDR_CR1, 16'h0040);
    wr(`GCR_ADDR_CR1, 16'h00C0);
    pulses(0, 0, "insert bit with pin source");
    gpio[5] = 1'b1;
    pulses(1, 0, "pin six rise");
    gpio[5] = 1'b0;
    wr(`GCR_ADDR_CR1, 16'h0000);
    pulses(0, 0, "source back to bit");
  endtask : t_err

  task automatic t_pm();
    wr(`GCR_ADDR_CR1, 16'h0008);
    pulses(0, 1, "update bit rise");
    pm_done_pulse();
    rdchk(`GCR_ADDR_SR, 16'h0001, "update done set");
    wr(`GCR_ADDR_CR1, 16'h0000);
    rdchk(`GCR_ADDR_SR, 16'h0000, "update done cleared by fall");
    wr(`GCR_ADDR_CR1, 16'h0010);
    wr(`GCR_ADDR_CR1, 16'h0018);
    pulses(0, 0, "update bit in pin mode");
    gpio[7] = 1'b1;
    pulses(0, 1, "pin eight rise");
    gpio[7] = 1'b0;
    for (int m = 2; m < 4; m++) begin
      wr(`GCR_ADDR_CR1, 16'(m << 4));
      pulses(0, 0, "tick mode entry");
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      pulses(0, 1, "second tick");
    end
    wr(`GCR_ADDR_CR1, 16'h0000);
  endtask : t_pm

  task automatic t_latched();
    wr(`GCR_ADDR_SRL, 16'h0001);
    rdchk(`GCR_ADDR_SRL, 16'h0000, "write one clears old");
    pm_done_pulse();
    rdchk(`GCR_ADDR_SRL, 16'h0001, "latched set");
    rdchk(`GCR_ADDR_SRL, 16'h0001, "read keeps in write mode");
    wr(`GCR_ADDR_SRL, 16'h0000);
    rdchk(`GCR_ADDR_SRL, 16'h0001, "write zero keeps");
    wr(`GCR_ADDR_SRL, 16'h0001);
    rdchk(`GCR_ADDR_SRL, 16'h0000, "write one clears");
    wr(`GCR_ADDR_CR1, 16'h0004);
    wr(`GCR_ADDR_SRIE, 16'h0001);
    pm_done_pulse();
    cyc(3);
    chk(16'({int_b, int_oe}), 16'h0001, "latched interrupt");
    rdchk(`GCR_ADDR_SRL, 16'h0001, "read returns old value");
    rdchk(`GCR_ADDR_SRL, 16'h0000, "read clears");
    wr(`GCR_ADDR_SRIE, 16'h0000);
  endtask : t_latched

  task automatic t_soft();
    rdchk(`GCR_ADDR_SR, 16'h0001, "done before soft reset");
    wr(`GCR_ADDR_ISRIE, 16'h1234);
    wr(`GCR_ADDR_CR1, 16'h4001);
    rdchk(`GCR_ADDR_CR1, 16'h0003, "soft reset control one");
    rdchk(`GCR_ADDR_ISRIE, 16'h0000, "soft reset enable");
    rdchk(`GCR_ADDR_SR, 16'h0000, "soft reset status");
    rdchk(`GCR_ADDR_CR2, 16'h0000, "soft reset control two");
    chk(cr2_out, 16'h0000, "soft reset control two out");
    chk(gio_ctrl, 16'h0000, "soft reset pin control out");
    chk(16'(dp_rst), 16'h0001, "datapath held in soft reset");
    wr(`GCR_ADDR_CR1, 16'h0002);
    rdchk(`GCR_ADDR_CR1, 16'h0002, "soft reset released");
    wr(`GCR_ADDR_CR1, 16'h0000);
    cyc(9);
    chk(16'(dp_rst), 16'h0001, "datapath reset minimum hold");
    cyc(21);
    chk(16'(dp_rst), 16'h0000, "datapath reset released");
  endtask : t_soft

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  task automatic conclude();
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_b = 1'b1;
    cyc(3);
    t_reset();
    t_access();
    t_irq();
    t_err();
    t_pm();
    t_latched();
    t_soft();
    conclude();
  end
endmodule : global_control_registers_tb
`default_nettype wire
